/* File: hdl/dioc_pkg.sv */
// Purpose: Shared constants and types for the sixteen-channel I/O configuration block
// Assumes: 25 MHz system clock, classic Wishbone register access
// Notes: Every offset, the global, link and channel field positions, reset values and timing counts live here
package dioc_pkg;
   localparam int NCH = 16;
   localparam int CLK_HZ = 25000000;
   // Bus map, byte addresses of 32-bit words
   localparam logic [7:0] A_GLOBAL = 8'h00;
   localparam logic [7:0] A_LINK = 8'h04;
   localparam logic [7:0] A_OUTCTL = 8'h08;
   localparam logic [7:0] A_INSTAT = 8'h0c;
   localparam logic [7:0] A_DIAG = 8'h10;
   localparam logic [7:0] A_ALTCFG = 8'h14;
   localparam logic [7:0] A_FORCE = 8'h18;
   localparam logic [7:0] A_CH_BASE = 8'h40;
   localparam logic [7:0] A_CH_LIM = 8'h80;
   // Global word fields
   localparam int F_ULMODE = 0;
   localparam int F_ACTMUTE = 2;
   localparam int F_USMUTE = 3;
   localparam int F_WEBLOCK = 5;
   localparam int F_FRCLOCK = 6;
   localparam int F_CFGLOCK = 9;
   // Link word fields
   localparam int F_CYCLIC = 0;
   localparam int F_PLCSTOP = 1;
   localparam int F_INTERR = 2;
   localparam int F_NEWCFG = 3;
   // Channel word fields
   localparam int F_SURV = 0;
   localparam int F_FSAFE = 8;
   localparam int F_DIR = 10;
   localparam int F_ARST = 12;
   localparam int F_INLOGIC = 13;
   localparam int F_FILT = 16;
   // Reset values
   localparam logic [1:0] RST_ULMODE = 2'h0;
   localparam logic [7:0] RST_SURV = 8'h50;
   localparam logic [1:0] RST_FSAFE = 2'h0;
   localparam logic [1:0] RST_DIR = 2'h3;
   localparam logic [15:0] RST_ILIM = 16'hffff;
   localparam logic [7:0] RST_FILT = 8'h00;
   // Timing: surveillance unit, steady fault filter, restart delay
   localparam int SURV_UNIT_MS = 1;
   localparam int STEADY_FILT_MS = 5;
   localparam int RESTART_MS = 100;
   localparam int MS_CYC = CLK_HZ / 1000;
   localparam int STEADY_CYC = STEADY_FILT_MS * MS_CYC;
   localparam int RESTART_CYC = RESTART_MS * MS_CYC;
   localparam int FILT_UNIT_CYC = MS_CYC / 10;
   typedef enum logic [1:0] {DIR_BIDIR = 2'b00, DIR_OUT = 2'b01, DIR_IN = 2'b10,
                             DIR_OFF = 2'b11} dioc_dir_e;
   typedef enum logic [1:0] {FS_LOW = 2'b00, FS_HIGH = 2'b01, FS_HOLD = 2'b10} dioc_fs_e;
   typedef struct packed {
      logic [15:0] ilim;
      logic [7:0] filt;
      logic [1:0] unused;
      logic inlogic;
      logic arst;
      logic [1:0] dir;
      logic [1:0] fsafe;
      logic [7:0] surv;
   } dioc_chcfg_s;
   typedef struct packed {
      logic [1:0] ulmode;
      logic actmute;
      logic usmute;
      logic weblock;
      logic frclock;
      logic cfglock;
   } dioc_glob_s;
endpackage : dioc_pkg

/* File: hdl/dioc_infilt.sv */
// Purpose: Per-channel input debounce and logic sense
// Assumes: Pin already synchronised
// Notes: Filter code counts in tenths of a millisecond
`timescale 1ns/1ps
module dioc_infilt
   import dioc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pin and settings
   input wire logic pin,
   input wire logic [7:0] code,
   input wire logic invert,
   // Result
   output logic level
);
   typedef struct packed {
      logic stable;
      logic [23:0] cnt;
      logic level;
   } dioc_flt_s;
   dioc_flt_s st_reg, st_next;
   logic [23:0] need;
   always_comb
   begin
      need = 24'(int'(code) * FILT_UNIT_CYC);
      st_next = st_reg;
      if (pin == st_reg.stable)
      begin
         st_next.cnt = 24'h0;
      end
      else if (st_reg.cnt + 24'h1 >= need)
      begin
         st_next.stable = pin;
         st_next.cnt = 24'h0;
      end
      else
      begin
         st_next.cnt = st_reg.cnt + 24'h1;
      end
      st_next.level = st_next.stable ^ invert;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end
   assign level = st_reg.level;
endmodule : dioc_infilt

/* File: hdl/dioc_outmon.sv */
// Purpose: Per-channel output drive, surveillance delay, fault filter and restart
// Assumes: Fault and current inputs already synchronised
// Notes: Restart delay is fixed; surveillance counts in milliseconds
`timescale 1ns/1ps
module dioc_outmon
   import dioc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Command and settings
   input wire logic cmd,
   input wire logic active,
   input wire logic [7:0] surv,
   input wire logic [15:0] ilim,
   input wire logic arst,
   input wire logic diag_en,
   // Plant
   input wire logic fault_raw,
   input wire logic [15:0] amps,
   // Results
   output logic drive,
   output logic diag
);
   typedef struct packed {
      logic cmd_d;
      logic tripped;
      logic [7:0] surv_ms;
      logic [15:0] ms_cnt;
      logic [17:0] flt_cnt;
      logic [21:0] rst_cnt;
      logic drive;
      logic diag;
   } dioc_om_s;
   dioc_om_s st_reg, st_next;
   logic bad;
   always_comb
   begin
      st_next = st_reg;
      bad = active && st_reg.drive && (fault_raw || amps > ilim);
      st_next.cmd_d = cmd;
      if (cmd && !st_reg.cmd_d)
      begin
         st_next.surv_ms = surv;
         st_next.ms_cnt = 16'h0;
         st_next.tripped = 1'b0;
      end
      else if (st_reg.surv_ms != 8'h0)
      begin
         if (st_reg.ms_cnt == 16'(SURV_UNIT_MS * MS_CYC - 1))
         begin
            st_next.ms_cnt = 16'h0;
            st_next.surv_ms = st_reg.surv_ms - 8'h1;
         end
         else
            st_next.ms_cnt = st_reg.ms_cnt + 16'h1;
      end
      // Monitoring waits for the delay, then steady faults need the fixed filter
      if (!bad || st_reg.surv_ms != 8'h0)
         st_next.flt_cnt = 18'h0;
      else if (st_reg.flt_cnt == 18'(STEADY_CYC - 1))
      begin
         st_next.flt_cnt = 18'h0;
         st_next.tripped = 1'b1;
         st_next.rst_cnt = 22'h0;
      end
      else
         st_next.flt_cnt = st_reg.flt_cnt + 18'h1;
      if (st_reg.tripped && arst)
      begin
         if (st_reg.rst_cnt == 22'(RESTART_CYC - 1))
         begin
            st_next.tripped = 1'b0;
            st_next.rst_cnt = 22'h0;
         end
         else
            st_next.rst_cnt = st_reg.rst_cnt + 22'h1;
      end
      st_next.drive = active && cmd && !st_next.tripped;
      st_next.diag = diag_en && active && st_next.tripped;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end
   assign drive = st_reg.drive;
   assign diag = st_reg.diag;
endmodule : dioc_outmon

/* File: hdl/dioc_top.sv */
// Purpose: Sixteen-channel digital I/O configuration and runtime core
// Assumes: Classic Wishbone slave, one 25 MHz clock, pins synchronised here
// Notes: Controller link is modelled as bus writes, link status included
`timescale 1ns/1ps
module dioc_top
   import dioc_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RESETN,
   // Wishbone slave, controller path
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // Alternative interface (web, REST and the like)
   input wire logic ALT_WR,
   input wire logic [7:0] ALT_ADR,
   input wire logic [31:0] ALT_DAT,
   input wire logic ALT_FORCE,
   input wire logic [15:0] ALT_FORCE_VAL,
   input wire logic WEB_REQ,
   output logic ALT_REJECT,
   output logic WEB_GRANT,
   output logic WEB_DENY,
   // Pins and plant monitors
   input wire logic [15:0] PIN_IN,
   input wire logic [15:0] PIN_FAULT,
   input wire logic [255:0] PIN_AMPS,
   input wire logic US_BAD,
   input wire logic UL_BAD,
   output logic [15:0] PIN_DRIVE,
   output logic [15:0] CH_DIAG,
   output logic US_DIAG,
   output logic UL_DIAG
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      dioc_glob_s glob;
      logic cyclic;
      logic plcstop;
      logic interr;
      logic [15:0] outctl;
      logic [15:0] held;
      logic frc_en;
      logic [15:0] frc_val;
      logic [15:0] drive;
      logic [15:0] chdiag;
      logic usdiag;
      logic uldiag;
      logic alt_rej;
      logic web_grant;
      logic web_deny;
      logic [15:0] instat;
   } dioc_core_s;
   dioc_core_s st_reg, st_next;
   dioc_chcfg_s [NCH-1:0] cfg_reg, cfg_next;
   // Two-stage synchronisers for pins and plant flags
   logic [33:0] sync1_reg, sync2_reg;
   logic [255:0] amps1_reg, amps2_reg;
   logic [15:0] pin_s, flt_s;
   logic us_s, ul_s;
   logic [15:0] filt_lvl, om_drive, om_diag, cmd_eff;
   logic wb_req, alt_ok, failsafe, ul_mute;
   logic [3:0] wb_idx, alt_idx;
   logic wb_ch, alt_ch;
   assign pin_s = sync2_reg[15:0];
   assign flt_s = sync2_reg[31:16];
   assign us_s = sync2_reg[32];
   assign ul_s = sync2_reg[33];
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         amps1_reg <= '0;
         amps2_reg <= '0;
      end
      else
      begin
         sync1_reg <= {UL_BAD, US_BAD, PIN_FAULT, PIN_IN};
         sync2_reg <= sync1_reg;
         amps1_reg <= PIN_AMPS;
         amps2_reg <= amps1_reg;
      end
   end
   // Per-channel datapath
   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_ch
         logic out_side, in_side;
         assign out_side = cfg_reg[g].dir == DIR_BIDIR || cfg_reg[g].dir == DIR_OUT;
         assign in_side = cfg_reg[g].dir == DIR_BIDIR || cfg_reg[g].dir == DIR_IN;
         dioc_infilt u_in (
            .clk(CLOCK),
            .rst_n(RESETN),
            .pin(pin_s[g]),
            .code(in_side ? cfg_reg[g].filt : RST_FILT),
            .invert(in_side & cfg_reg[g].inlogic),
            .level(filt_lvl[g])
         );
         dioc_outmon u_out (
            .clk(CLOCK),
            .rst_n(RESETN),
            .cmd(cmd_eff[g]),
            .active(out_side),
            .surv(cfg_reg[g].surv),
            .ilim(cfg_reg[g].ilim),
            .arst(cfg_reg[g].arst),
            .diag_en(!(ul_mute && ul_s)),
            .fault_raw(flt_s[g]),
            .amps(amps2_reg[g*16 +: 16]),
            .drive(om_drive[g]),
            .diag(om_diag[g])
         );
      end
   endgenerate
   // Output command: forcing, then failsafe substitution
   assign failsafe = st_reg.interr || st_reg.plcstop || !st_reg.cyclic;
   always_comb
   begin
      for (int i = 0; i < NCH; i++)
      begin
         if (st_reg.frc_en)
            cmd_eff[i] = st_reg.frc_val[i];
         else if (!failsafe)
            cmd_eff[i] = st_reg.outctl[i];
         else if (cfg_reg[i].fsafe == FS_HIGH)
            cmd_eff[i] = 1'b1;
         else if (cfg_reg[i].fsafe == FS_HOLD)
            cmd_eff[i] = st_reg.held[i];
         else
            cmd_eff[i] = 1'b0;
      end
   end
   assign ul_mute = st_reg.glob.actmute;
   assign wb_req = WB_CYC_I && WB_STB_I && !st_reg.ack;
   assign wb_idx = WB_ADR_I[5:2];
   assign wb_ch = WB_ADR_I >= A_CH_BASE && WB_ADR_I < A_CH_LIM;
   assign alt_idx = ALT_ADR[5:2];
   assign alt_ch = ALT_ADR >= A_CH_BASE && ALT_ADR < A_CH_LIM;
   assign alt_ok = !st_reg.glob.cfglock && !st_reg.cyclic;
   always_comb
   begin
      st_next = st_reg;
      cfg_next = cfg_reg;
      st_next.ack = wb_req;
      st_next.rdat = 32'h0;
      st_next.alt_rej = 1'b0;
      st_next.web_grant = WEB_REQ && !st_reg.glob.weblock;
      st_next.web_deny = WEB_REQ && st_reg.glob.weblock;
      // Hold-last snapshot only tracks valid live data
      if (!failsafe)
         st_next.held = st_reg.outctl;
      if (ALT_WR)
      begin
         // Current limit sits above the 24 written bits and keeps its stored value
         if (alt_ok && alt_ch)
            cfg_next[alt_idx] = {cfg_reg[alt_idx].ilim, ALT_DAT[23:0]};
         else if (alt_ok && ALT_ADR == A_GLOBAL)
            st_next.glob = {ALT_DAT[F_ULMODE +: 2], ALT_DAT[F_ACTMUTE], ALT_DAT[F_USMUTE],
               ALT_DAT[F_WEBLOCK], ALT_DAT[F_FRCLOCK], ALT_DAT[F_CFGLOCK]};
         else
            st_next.alt_rej = 1'b1;
      end
      if (ALT_FORCE)
      begin
         if (st_reg.glob.frclock)
            st_next.alt_rej = 1'b1;
         else
         begin
            st_next.frc_en = 1'b1;
            st_next.frc_val = ALT_FORCE_VAL;
         end
      end
      if (st_reg.glob.frclock)
         st_next.frc_en = 1'b0;
      // Controller writes come last so they overwrite alternative values
      if (wb_req && WB_WE_I && WB_SEL_I == 4'hf)
      begin
         if (wb_ch)
            cfg_next[wb_idx] = {cfg_reg[wb_idx].ilim, WB_DAT_I[23:0]};
         else
            case (WB_ADR_I)
               A_GLOBAL: st_next.glob = {WB_DAT_I[F_ULMODE +: 2], WB_DAT_I[F_ACTMUTE],
                  WB_DAT_I[F_USMUTE], WB_DAT_I[F_WEBLOCK], WB_DAT_I[F_FRCLOCK],
                  WB_DAT_I[F_CFGLOCK]};
               A_LINK:
               begin
                  st_next.cyclic = WB_DAT_I[F_CYCLIC];
                  st_next.plcstop = WB_DAT_I[F_PLCSTOP];
                  st_next.interr = WB_DAT_I[F_INTERR];
                  if (WB_DAT_I[F_NEWCFG])
                     st_next.frc_en = 1'b0;
               end
               A_OUTCTL: st_next.outctl = WB_DAT_I[15:0];
               A_FORCE: st_next.frc_en = 1'b0;
               default: st_next.rdat = 32'h0;
            endcase
      end
      else if (wb_req && !WB_WE_I)
      begin
         if (wb_ch)
            st_next.rdat = {8'h0, cfg_reg[wb_idx][23:0]};
         else
            case (WB_ADR_I)
               A_GLOBAL: st_next.rdat = 32'({st_reg.glob.cfglock, 2'h0, st_reg.glob.frclock,
                  st_reg.glob.weblock, 1'b0, st_reg.glob.usmute, st_reg.glob.actmute,
                  st_reg.glob.ulmode});
               A_LINK: st_next.rdat = 32'({st_reg.interr, st_reg.plcstop, st_reg.cyclic});
               A_OUTCTL: st_next.rdat = 32'(st_reg.outctl);
               A_INSTAT: st_next.rdat = 32'(st_reg.instat);
               A_DIAG: st_next.rdat = {12'h0, st_reg.uldiag, st_reg.usdiag, 2'h0,
                  st_reg.chdiag};
               A_FORCE: st_next.rdat = {15'h0, st_reg.frc_en, st_reg.frc_val};
               default: st_next.rdat = 32'h0;
            endcase
      end
      for (int i = 0; i < NCH; i++)
      begin
         // Input status only from channels with input function
         st_next.instat[i] = (cfg_reg[i].dir == DIR_BIDIR || cfg_reg[i].dir == DIR_IN)
            && filt_lvl[i];
      end
      st_next.drive = om_drive;
      st_next.chdiag = om_diag;
      st_next.usdiag = us_s && !st_reg.glob.usmute;
      // Auto mode reports only while the cyclic link flag is set
      case (st_reg.glob.ulmode)
         2'h0: st_next.uldiag = ul_s;
         2'h2: st_next.uldiag = ul_s && st_reg.cyclic;
         default: st_next.uldiag = 1'b0;
      endcase
   end
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         st_reg <= '0;
         for (int i = 0; i < NCH; i++)
         begin
            cfg_reg[i] <= {RST_ILIM, RST_FILT, 2'h0, 1'b0, 1'b0, RST_DIR, RST_FSAFE,
               RST_SURV};
         end
      end
      else
      begin
         st_reg <= st_next;
         cfg_reg <= cfg_next;
      end
   end
   assign WB_ACK_O = st_reg.ack;
   assign WB_DAT_O = st_reg.rdat;
   assign ALT_REJECT = st_reg.alt_rej;
   assign WEB_GRANT = st_reg.web_grant;
   assign WEB_DENY = st_reg.web_deny;
   assign PIN_DRIVE = st_reg.drive;
   assign CH_DIAG = st_reg.chdiag;
   assign US_DIAG = st_reg.usdiag;
   assign UL_DIAG = st_reg.uldiag;
endmodule : dioc_top

/* File: test/dioc_top_assertions.sv */
// Purpose: Port-level checks for the I/O configuration core
// Assumes: Locks and link state change only through bus writes
// Notes: Shadows mirror bus writes; alternative writes are not mirrored
`timescale 1ns/1ps
module dioc_top_assertions
   import dioc_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RESETN,
   // Bus
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   // Alternative side and supplies
   input wire logic ALT_WR,
   input wire logic ALT_FORCE,
   input wire logic WEB_REQ,
   input wire logic ALT_REJECT,
   input wire logic WEB_GRANT,
   input wire logic WEB_DENY,
   input wire logic US_DIAG,
   input wire logic UL_DIAG
);
   logic wr_ok;
   logic web_lk, frc_lk, cfg_lk, us_mute, cyc_on;
   logic [1:0] ul_m;
   assign wr_ok = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_SEL_I == 4'hf;
   // Writes land at the edge that samples ack high, one cycle after the core
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         {web_lk, frc_lk, cfg_lk, us_mute, cyc_on} <= 5'h00;
         ul_m <= 2'h0;
      end
      else if (wr_ok && WB_ADR_I == A_GLOBAL)
      begin
         web_lk <= WB_DAT_I[F_WEBLOCK];
         frc_lk <= WB_DAT_I[F_FRCLOCK];
         cfg_lk <= WB_DAT_I[F_CFGLOCK];
         us_mute <= WB_DAT_I[F_USMUTE];
         ul_m <= WB_DAT_I[F_ULMODE+:2];
      end
      else if (wr_ok && WB_ADR_I == A_LINK)
         cyc_on <= WB_DAT_I[F_CYCLIC];
   end
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESETN);
   a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("bus request not answered next cycle");
   a_dat_idle_zero: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
      else $error("read data not zero outside ack");
   a_web_answer: assert property (WEB_REQ |=> WEB_GRANT != WEB_DENY)
      else $error("web request without single answer");
   a_web_locked: assert property (WEB_REQ && web_lk |=> WEB_DENY)
      else $error("web request granted while locked");
   a_reject_cause: assert property (ALT_REJECT |-> $past(ALT_WR) || $past(ALT_FORCE))
      else $error("reject without alternative request");
   a_force_locked: assert property (ALT_FORCE && frc_lk |=> ALT_REJECT)
      else $error("force accepted while locked");
   a_cfg_refused: assert property (ALT_WR && (cfg_lk || cyc_on) |=> ALT_REJECT)
      else $error("alternative write accepted while locked or cyclic");
   a_us_muted: assert property (us_mute [*3] |-> !US_DIAG)
      else $error("system supply diagnosis while muted");
   a_ul_muted: assert property ((ul_m == 2'h1) [*3] |-> !UL_DIAG)
      else $error("actuator supply diagnosis while suppressed");
endmodule : dioc_top_assertions
bind dioc_top dioc_top_assertions dioc_top_assertions_i (.CLOCK(CLOCK), .RESETN(RESETN),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
   .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .ALT_WR(ALT_WR), .ALT_FORCE(ALT_FORCE), .WEB_REQ(WEB_REQ), .ALT_REJECT(ALT_REJECT),
   .WEB_GRANT(WEB_GRANT), .WEB_DENY(WEB_DENY), .US_DIAG(US_DIAG), .UL_DIAG(UL_DIAG));

/* File: test/dioc_plc_model.sv */
// Purpose: Controller side of the configuration link, as a bus master
// Assumes: Classic single cycles, slave answers in its own time
// Notes: Write data is scrambled once released so stale values never match
`timescale 1ns/1ps
module dioc_plc_model
   import dioc_pkg::*;
(
   // Clock
   input wire logic clk,
   // Master side
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [7:0] adr,
   output logic [3:0] sel,
   output logic [31:0] dat,
   input wire logic [31:0] rdat,
   input wire logic ack
);
   initial
   begin
      {cyc, stb, we} = 3'h0;
      adr = 8'h00;
      sel = 4'h0;
      dat = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      dat <= ~d;
   endtask : xfer
endmodule : dioc_plc_model

/* File: test/dioc_top_test.sv */
// Purpose: Self-checking bench for the I/O configuration core
// Assumes: Core answers bus requests itself; pins settle within a few cycles
// Notes: Long fault filters are not exercised, only the 1 ms input filter
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module dioc_top_test;
   import dioc_pkg::*;
   logic CLOCK, RESETN, wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] wb_adr, alt_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_wdat, wb_rdat, alt_dat, rd_v;
   logic alt_wr, alt_force, web_req, alt_reject, web_grant, web_deny;
   logic us_bad, ul_bad, us_diag, ul_diag;
   logic [15:0] force_val, pin_in, pin_fault, pin_drive, ch_diag;
   logic [255:0] pin_amps;
   int n_errors = 0;
   int compares = 0;
   int i;
   logic [1:0] fs_tab [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
   logic ctl_tab [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
   logic [3:0] lnk_tab [5] = '{4'h3, 4'h3, 4'h0, 4'h0, 4'h5};
   logic exp_tab [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
   dioc_top dioc_top_i (.CLOCK(CLOCK), .RESETN(RESETN), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
      .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_wdat),
      .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack), .ALT_WR(alt_wr), .ALT_ADR(alt_adr),
      .ALT_DAT(alt_dat), .ALT_FORCE(alt_force), .ALT_FORCE_VAL(force_val), .WEB_REQ(web_req),
      .ALT_REJECT(alt_reject), .WEB_GRANT(web_grant), .WEB_DENY(web_deny), .PIN_IN(pin_in),
      .PIN_FAULT(pin_fault), .PIN_AMPS(pin_amps), .US_BAD(us_bad), .UL_BAD(ul_bad),
      .PIN_DRIVE(pin_drive), .CH_DIAG(ch_diag), .US_DIAG(us_diag), .UL_DIAG(ul_diag));
   dioc_plc_model dioc_plc_model_i (.clk(CLOCK), .cyc(wb_cyc), .stb(wb_stb), .we(wb_we),
      .adr(wb_adr), .sel(wb_sel), .dat(wb_wdat), .rdat(wb_rdat), .ack(wb_ack));
   initial
   begin
      CLOCK = 1'b0;
      forever #20 CLOCK = ~CLOCK;
   end
   task complete_run;
      if (n_errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run
   task automatic tick(input int n);
      repeat (n) @(posedge CLOCK);
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      dioc_plc_model_i.xfer(1'b1, a, 4'hf, d, rd_v);
   endtask : wr
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      logic [31:0] q;
      dioc_plc_model_i.xfer(1'b0, a, 4'hf, 32'h0, q);
      `CHK(n, e & m, q & m)
   endtask : rdc
   task automatic alt_op(input logic f, input logic [7:0] a, input logic [31:0] d,
                         input logic rej);
      @(posedge CLOCK);
      alt_wr <= !f;
      alt_force <= f;
      alt_adr <= a;
      alt_dat <= d;
      @(posedge CLOCK);
      alt_wr <= 1'b0;
      alt_force <= 1'b0;
      @(posedge CLOCK);
      `CHK("alt_reject", rej, alt_reject)
   endtask : alt_op
   task automatic web(input logic deny);
      @(posedge CLOCK);
      web_req <= 1'b1;
      @(posedge CLOCK);
      web_req <= 1'b0;
      @(posedge CLOCK);
      `CHK("web_grant", !deny, web_grant)
      `CHK("web_deny", deny, web_deny)
   endtask : web
   // Channel word with default surveillance delay
   function automatic logic [31:0] chw(input logic [1:0] dir, input logic [1:0] fs,
                                       input logic inl, input logic [7:0] filt);
      chw = {24'h0, RST_SURV};
      chw[F_DIR+:2] = dir;
      chw[F_FSAFE+:2] = fs;
      chw[F_INLOGIC] = inl;
      chw[F_FILT+:8] = filt;
   endfunction : chw
   initial
   begin
      repeat (60000) @(posedge CLOCK);
      n_errors++;
      complete_run();
   end
   initial
   begin
      {RESETN, alt_wr, alt_force, web_req, us_bad, ul_bad} = 6'h00;
      alt_adr = 8'h00;
      alt_dat = 32'h0;
      force_val = 16'h5a3c;
      {pin_in, pin_fault} = 32'h0;
      pin_amps = '0;
      tick(6);
      RESETN <= 1'b1;
      `CHK("drive_rst", 16'h0000, pin_drive)
      rdc("glob_rst", A_GLOBAL, 32'h0000_027f, 32'h0);
      for (i = 0; i < NCH; i++)
         rdc("ch_rst", A_CH_BASE + 8'(4 * i), 32'h00ff_ffff, 32'h0000_0c50);
      rdc("unmapped", 8'h20, 32'hffff_ffff, 32'h0);
      for (i = 0; i < 3; i++)
      begin
         wr(A_GLOBAL, 32'(i));
         rdc("ulmode", A_GLOBAL, 32'h3, 32'(i));
      end
      dioc_plc_model_i.xfer(1'b1, A_GLOBAL, 4'h3, 32'h0000_0008, rd_v);
      rdc("partial", A_GLOBAL, 32'h0000_027f, 32'h2);
      wr(A_GLOBAL, 32'h0000_000c);
      rdc("mutes", A_GLOBAL, 32'h0000_027f, 32'h0000_000c);
      @(posedge CLOCK);
      us_bad <= 1'b1;
      ul_bad <= 1'b1;
      tick(20);
      `CHK("us_muted", 1'b0, us_diag)
      `CHK("ul_diag", 1'b1, ul_diag)
      wr(A_GLOBAL, 32'h1);
      tick(20);
      `CHK("us_diag", 1'b1, us_diag)
      `CHK("ul_muted", 1'b0, ul_diag)
      us_bad <= 1'b0;
      ul_bad <= 1'b0;
      wr(A_GLOBAL, 32'h0);
      web(1'b0);
      wr(A_GLOBAL, 32'h1 << F_WEBLOCK);
      web(1'b1);
      wr(A_GLOBAL, 32'h1 << F_FRCLOCK);
      alt_op(1'b1, 8'h00, 32'h0, 1'b1);
      wr(A_GLOBAL, 32'h0);
      alt_op(1'b1, 8'h00, 32'h0, 1'b0);
      rdc("force", A_FORCE, 32'h0001_ffff, {15'h0, 1'b1, force_val});
      wr(A_FORCE, 32'h0);
      wr(A_GLOBAL, 32'h1 << F_CFGLOCK);
      alt_op(1'b0, 8'h54, chw(DIR_OUT, FS_HIGH, 1'b0, 8'h00), 1'b1);
      wr(A_GLOBAL, 32'h0);
      wr(A_LINK, 32'h1);
      alt_op(1'b0, 8'h54, chw(DIR_OUT, FS_HIGH, 1'b0, 8'h00), 1'b1);
      rdc("alt_kept", 8'h54, 32'h00ff_ffff, 32'h0000_0c50);
      wr(A_LINK, 32'h0);
      alt_op(1'b0, 8'h54, chw(DIR_OUT, FS_HIGH, 1'b0, 8'h00), 1'b0);
      rdc("alt_cfg", 8'h54, 32'h00ff_ffff, chw(DIR_OUT, FS_HIGH, 1'b0, 8'h00));
      wr(8'h54, chw(DIR_IN, FS_LOW, 1'b1, 8'h00));
      rdc("plc_cfg", 8'h54, 32'h00ff_ffff, chw(DIR_IN, FS_LOW, 1'b1, 8'h00));
      wr(8'h40, chw(DIR_OUT, FS_LOW, 1'b0, 8'h00));
      wr(8'h48, chw(DIR_IN, FS_LOW, 1'b0, 8'h00));
      wr(8'h4c, chw(DIR_BIDIR, FS_LOW, 1'b0, 8'h00));
      wr(A_LINK, 32'h1);
      wr(A_OUTCTL, 32'h0000_000f);
      pin_in <= 16'h000f;
      pin_fault <= 16'h0002;
      tick(10);
      `CHK("diag_off", 16'h0000, ch_diag)
      `CHK("drive_dir", 4'b1001, pin_drive[3:0])
      rdc("in_dir", A_INSTAT, 32'hf, 32'hc);
      wr(8'h48, chw(DIR_IN, FS_LOW, 1'b1, 8'h00));
      tick(10);
      rdc("in_nc", A_INSTAT, 32'hf, 32'h8);
      for (i = 0; i < 5; i++)
      begin
         wr(8'h40, chw(DIR_OUT, fs_tab[i], 1'b0, 8'h00));
         wr(A_LINK, 32'h1);
         wr(A_OUTCTL, {31'h0, ctl_tab[i]});
         tick(4);
         `CHK("drive_live", ctl_tab[i], pin_drive[0])
         wr(A_LINK, {28'h0, lnk_tab[i]});
         tick(4);
         `CHK("failsafe", exp_tab[i], pin_drive[0])
      end
      // Pin held high for long, so the 1 ms filter must delay the fall
      wr(A_LINK, 32'h1);
      wr(8'h48, chw(DIR_IN, FS_LOW, 1'b0, 8'd10));
      tick(10);
      pin_in <= 16'h000b;
      tick(MS_CYC / 2);
      rdc("filt_hold", A_INSTAT, 32'h4, 32'h4);
      tick(MS_CYC * 3 / 4);
      rdc("filt_pass", A_INSTAT, 32'h4, 32'h0);
      complete_run();
   end
endmodule : dioc_top_test
